// >>> logic/roc_map.svh
`ifndef ROC_MAP_SVH
`define ROC_MAP_SVH

// Byte offsets on the register bus
`define ROC_OFF_CTRL       8'h00
`define ROC_OFF_DRV_LOW    8'h04
`define ROC_OFF_DRV_HIGH   8'h08
`define ROC_OFF_PAUSE      8'h0C
`define ROC_OFF_DIV        8'h10
`define ROC_OFF_PHASE      8'h14
`define ROC_OFF_STATUS     8'h18
`define ROC_OFF_RAWBIT     8'h1C
`define ROC_OFF_COUNT      8'h20

// Pause-control codes
`define ROC_PAUSE_CODE     32'h636F6D61
`define ROC_RESUME_CODE    32'h77616B65

// Divider field: pass value plus divisor
`define ROC_DIV_PASS       12'hAA0
`define ROC_DIV_LAST       12'hABF
`define ROC_DIV_RESET      12'hAB0
`define ROC_DIV_FULL       6'h20

// Phase register fields
`define ROC_PH_PW_HI       11
`define ROC_PH_PW_LO       4
`define ROC_PH_EN_BIT      3
`define ROC_PH_FLIP_BIT    2
`define ROC_PH_PASS        8'hAA
`define ROC_PH_RESET       12'h008

// Status fields
`define ROC_ST_STABLE      31
`define ROC_ST_BADWR       24
`define ROC_ST_DIVRUN      16
`define ROC_ST_ENABLED     12

// Control and drive-strength codes checked for bad writes
`define ROC_EN_OFF         12'hD1E
`define ROC_EN_ON          12'hFAB
`define ROC_RNG_LOW        12'hFA4
`define ROC_RNG_MED        12'hFA5
`define ROC_RNG_HIGH       12'hFA7
`define ROC_RNG_TOOHIGH    12'hFA6
`define ROC_DRV_PASS       16'h9696

// Stability watch
`define ROC_STABLE_EDGES   3'h4
`define ROC_EDGE_TIMEOUT   7'h40

`endif

// >>> logic/roc_pkg.sv
package roc_pkg;
  typedef enum logic [1:0] {
    ROC_RUN   = 2'b01,
    ROC_PAUSE = 2'b10
  } roc_mode_t;
endpackage

// >>> logic/roc_sync.sv
`timescale 1ns/1ps
module roc_sync #(
  parameter int         W   = 1,
  parameter logic [0:0] RST = 1'b0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= {W{RST}};
      sync_q <= {W{RST}};
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // roc_sync

// >>> logic/roc_divider.sv
`timescale 1ns/1ps
`include "roc_map.svh"
module roc_divider (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Sampled oscillator
  input  wire logic       osc_lvl_i,
  input  wire logic       osc_rise_i,
  input  wire logic       run_i,
  // Settings
  input  wire logic [5:0] div_i,
  input  wire logic       ph_en_i,
  input  wire logic       ph_flip_i,
  input  wire logic [1:0] ph_shift_i,
  // Outputs
  output logic            div_clk_o,
  output logic            phase_clk_o
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       half_q;
  logic [2:0] dly_q;
  logic       div_q;
  logic       ph_q;
  wire  [5:0] cnt_inc  = {1'b0, cnt_q} + 6'h01;
  wire        wrap     = (cnt_inc >= div_i);
  wire  [5:0] half     = (div_i + 6'h01) >> 1;
  wire        div_one  = (div_i == 6'h01);
  wire        base     = div_one ? osc_lvl_i : half_q;
  wire        shifted  = (ph_shift_i == 2'h0) ? base : dly_q[ph_shift_i - 2'h1];
  wire        flipped  = shifted ^ (ph_flip_i & ~div_one);
  assign cnt_d = wrap ? 5'h00 : cnt_inc[4:0];

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= 5'h00;
      half_q <= 1'b0;
      dly_q  <= 3'h0;
    end
    else if (osc_rise_i && run_i)
    begin
      cnt_q  <= cnt_d;
      half_q <= ({1'b0, cnt_d} < half);
      dly_q  <= {dly_q[1:0], base};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 1'b0;
      ph_q  <= 1'b0;
    end
    else
    begin
      div_q <= base;
      ph_q  <= ph_en_i & flipped;
    end
  end

  assign div_clk_o   = div_q;
  assign phase_clk_o = ph_q;
endmodule // roc_divider

// >>> logic/roc_ctrl_top.sv
// Overview of operation
// - Pause code stops the oscillator, resume code runs it.
// - Resets to resume; any other written value also selects resume.
// - Divider field is pass plus divisor; zero divides by 32, else by divisor.
// - Out-of-range divider field forces divide by 32.
// - Divider resets to divide by sixteen.
// - Phase settings apply only with the pass value; otherwise enabled, zero shift.
// - Phase bit 3 gates the phase output, resets to one.
// - Phase bit 2 inverts the phase output, ignored at divide by one.
// - Shift field delays the phase output by that many oscillator cycles, except at divide by one.
// - Status bit 31 shows oscillator running and stable, resets zero.
// - Bad writes set status bit 24; a status write clears it.
// - Enabled and divider-running flags reset zero, rise during startup.
// - Raw-sample bit 0 reads the live oscillator level, one after reset.
// - Count field decrements per oscillator cycle to zero and holds.
// - Nonzero count write loads and starts; zero write is ignored, so a running count keeps running.
// - Enable field knows disable and enable codes; others enable and are bad.
// - Drive-strength writes need the pass value in the upper half.
// - Range field accepts four Gray codes; others are bad writes.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "roc_map.svh"
module roc_ctrl_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Oscillator side
  input  wire logic        osc_i,
  output logic             osc_run_o,
  output logic             div_clk_o,
  output logic             phase_clk_o
);
  roc_pkg::roc_mode_t mode_q;
  logic [11:0] div_q;
  logic [11:0] phase_q;
  logic        badwr_q;
  logic [7:0]  count_q;
  logic        enabled_q;
  logic        divrun_q;
  logic        stable_q;
  logic [2:0]  edges_q;
  logic [6:0]  idle_q;
  logic        osc_prev_q;
  logic [31:0] rdata_q;
  logic        osc_lvl;

  // Bus decode
  wire setup  = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire wr     = access & pwrite_i;
  wire hit_ctrl  = (paddr_i == `ROC_OFF_CTRL);
  wire hit_drvl  = (paddr_i == `ROC_OFF_DRV_LOW);
  wire hit_drvh  = (paddr_i == `ROC_OFF_DRV_HIGH);
  wire hit_pause = (paddr_i == `ROC_OFF_PAUSE);
  wire hit_div   = (paddr_i == `ROC_OFF_DIV);
  wire hit_phase = (paddr_i == `ROC_OFF_PHASE);
  wire hit_stat  = (paddr_i == `ROC_OFF_STATUS);
  wire hit_raw   = (paddr_i == `ROC_OFF_RAWBIT);
  wire hit_count = (paddr_i == `ROC_OFF_COUNT);
  wire mapped    = hit_ctrl | hit_drvl | hit_drvh | hit_pause | hit_div
                 | hit_phase | hit_stat | hit_raw | hit_count;

  // Oscillator sampling
  roc_sync #(
    .W   (1),
    .RST (1'b1)
  ) u_osc_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (osc_i),
    .q_o     (osc_lvl)
  );
  wire osc_rise = osc_lvl & ~osc_prev_q;

  // Bad-write checks on the control, drive and pause registers
  wire [11:0] en_fld  = pwdata_i[23:12];
  wire [11:0] rng_fld = pwdata_i[11:0];
  wire en_ok  = (en_fld == `ROC_EN_OFF) | (en_fld == `ROC_EN_ON);
  wire rng_ok = (rng_fld == `ROC_RNG_LOW) | (rng_fld == `ROC_RNG_MED)
              | (rng_fld == `ROC_RNG_HIGH) | (rng_fld == `ROC_RNG_TOOHIGH);
  wire drv_ok = (pwdata_i[31:16] == `ROC_DRV_PASS);
  wire is_pause  = (pwdata_i == `ROC_PAUSE_CODE);
  wire is_resume = (pwdata_i == `ROC_RESUME_CODE);
  wire bad_ctrl  = hit_ctrl & ~(en_ok & rng_ok);
  wire bad_drv   = (hit_drvl | hit_drvh) & ~drv_ok;
  wire bad_pause = hit_pause & ~(is_pause | is_resume);
  wire bad_set   = wr & (bad_ctrl | bad_drv | bad_pause);
  wire bad_clr   = wr & hit_stat;

  // Divider field check
  wire div_ok = (pwdata_i[11:0] >= `ROC_DIV_PASS) & (pwdata_i[11:0] <= `ROC_DIV_LAST);
  // Stored field is always within pass..last, so the low five bits are the divisor
  wire [11:0] div_off = div_q - `ROC_DIV_PASS;
  wire [4:0]  div_raw = div_off[4:0];
  wire [5:0] div_eff = (div_raw == 5'h00) ? `ROC_DIV_FULL : {1'b0, div_raw};

  // Phase settings
  wire ph_pass  = (phase_q[`ROC_PH_PW_HI:`ROC_PH_PW_LO] == `ROC_PH_PASS);
  wire ph_en    = ph_pass ? phase_q[`ROC_PH_EN_BIT] : 1'b1;
  wire ph_flip  = ph_pass & phase_q[`ROC_PH_FLIP_BIT];
  wire [1:0] ph_shift = ph_pass ? phase_q[1:0] : 2'h0;
  wire running  = (mode_q == roc_pkg::ROC_RUN);

  // Read mux
  wire [31:0] st_word = {stable_q, 6'h00, badwr_q, 7'h00, divrun_q, 3'h0, enabled_q, 12'h000};
  wire [31:0] pause_word = running ? `ROC_RESUME_CODE : `ROC_PAUSE_CODE;
  wire [31:0] rd_mux = hit_pause ? pause_word
                     : hit_div   ? {20'h00000, div_q}
                     : hit_phase ? {20'h00000, phase_q}
                     : hit_stat  ? st_word
                     : hit_raw   ? {31'h00000000, osc_lvl}
                     : hit_count ? {24'h000000, count_q}
                     : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_q <= 32'h00000000;
    else if (setup & ~pwrite_i)
      rdata_q <= rd_mux;
  end

  // Pause control
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      mode_q <= roc_pkg::ROC_RUN;
    else if (wr && hit_pause)
    begin
      case (is_pause)
        1'b1:    mode_q <= roc_pkg::ROC_PAUSE;
        default: mode_q <= roc_pkg::ROC_RUN;
      endcase
    end
  end

  // Divider and phase registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_q   <= `ROC_DIV_RESET;
      phase_q <= `ROC_PH_RESET;
    end
    else
    begin
      if (wr && hit_div)
        div_q <= div_ok ? pwdata_i[11:0] : `ROC_DIV_PASS;
      if (wr && hit_phase)
        phase_q <= pwdata_i[11:0];
    end
  end

  // Sticky bad-write flag, set beats clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      badwr_q <= 1'b0;
    else if (bad_set)
      badwr_q <= 1'b1;
    else if (bad_clr)
      badwr_q <= 1'b0;
  end

  // Down counter, a bus load beats the decrement
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      count_q <= 8'h00;
    else if (wr && hit_count && pwdata_i[7:0] != 8'h00)
      count_q <= pwdata_i[7:0];
    else if (osc_rise && count_q != 8'h00)
      count_q <= count_q - 8'h01;
  end

  // Startup flags and stability watch
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      enabled_q  <= 1'b0;
      divrun_q   <= 1'b0;
      stable_q   <= 1'b0;
      edges_q    <= 3'h0;
      idle_q     <= 7'h00;
      osc_prev_q <= 1'b1;
    end
    else
    begin
      osc_prev_q <= osc_lvl;
      enabled_q  <= 1'b1;
      if (enabled_q && osc_rise)
        divrun_q <= 1'b1;
      // A paused or silent ring drops stable at once
      if (!running || idle_q == `ROC_EDGE_TIMEOUT)
      begin
        edges_q <= 3'h0;
        idle_q  <= 7'h00;
      end
      else if (osc_rise)
      begin
        idle_q <= 7'h00;
        if (edges_q != `ROC_STABLE_EDGES)
          edges_q <= edges_q + 3'h1;
      end
      else
        idle_q <= idle_q + 7'h01;
      stable_q <= running & (edges_q == `ROC_STABLE_EDGES)
                & (idle_q != `ROC_EDGE_TIMEOUT);
    end
  end

  roc_divider u_div (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .osc_lvl_i   (osc_lvl),
    .osc_rise_i  (osc_rise),
    .run_i       (running),
    .div_i       (div_eff),
    .ph_en_i     (ph_en),
    .ph_flip_i   (ph_flip),
    .ph_shift_i  (ph_shift),
    .div_clk_o   (div_clk_o),
    .phase_clk_o (phase_clk_o)
  );

  assign osc_run_o = running;
  assign prdata_o  = rdata_q;
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;
endmodule // roc_ctrl_top

// >>> testbench/roc_ctrl_chk.sv
`timescale 1ns/1ps
`include "roc_map.svh"
module roc_ctrl_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Bus
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Oscillator
  input wire logic        osc_i,
  input wire logic        osc_run_o,
  input wire logic        div_clk_o,
  input wire logic        phase_clk_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire acc = psel_i & penable_i;
  wire rd  = acc & ~pwrite_i;
  wire bad = (paddr_i > 8'h20) | (paddr_i[1:0] != 2'h0);
  wire pwr = acc & pwrite_i & (paddr_i == `ROC_OFF_PAUSE);
  sequence pause_wr;
    pwr && pwdata_i == `ROC_PAUSE_CODE;
  endsequence
  sequence wake_wr;
    pwr && pwdata_i != `ROC_PAUSE_CODE;
  endsequence
  ready_a: assert property (acc |-> pready_o) else $error("pready low");
  unmapped_err_a: assert property (acc && bad |-> pslverr_o) else $error("no slverr");
  mapped_ok_a: assert property (acc && !bad |-> !pslverr_o) else $error("bad slverr");
  pause_stop_a: assert property (pause_wr |=> !osc_run_o) else $error("no pause");
  wake_run_a: assert property (wake_wr |=> osc_run_o) else $error("no wake");
  reset_wake_a: assert property ($rose(rst_n_i) |-> osc_run_o && !div_clk_o)
    else $error("reset state");
  pause_hold_a: assert property ((!osc_run_o) [*4] |=> $stable(div_clk_o))
    else $error("divider moved while paused");
  raw_upper_a: assert property (rd && paddr_i == `ROC_OFF_RAWBIT |-> prdata_o[31:1] == 31'h0)
    else $error("raw bits");
  count_upper_a: assert property (rd && paddr_i == `ROC_OFF_COUNT |-> prdata_o[31:8] == 24'h0)
    else $error("count bits");
endmodule // roc_ctrl_chk

bind roc_ctrl_top roc_ctrl_chk chk_i (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .osc_i, .osc_run_o, .div_clk_o,
  .phase_clk_o);

// >>> testbench/ring_osc_control_tail_bench.sv
`timescale 1ns/1ps
`include "roc_map.svh"
module ring_osc_control_tail_bench;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        osc_i = 1'b1;
  logic        osc_on = 1'b0;
  logic [1:0]  oc = 2'h0;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, osc_run_o, div_clk_o, phase_clk_o, er;
  int          mismatches = 0;
  int          comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  // Oscillator period 8 clk, slow enough for the sampler
  always @(posedge clk_i)
  begin
    oc <= oc + 2'h1;
    if (osc_on && oc == 2'h3)
      osc_i <= ~osc_i;
  end
  roc_ctrl_top uut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .osc_i, .osc_run_o, .div_clk_o, .phase_clk_o);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic per(input int e);
    time t;
    @(posedge div_clk_o);
    @(posedge div_clk_o);
    t = $time;
    @(posedge div_clk_o);
    chk(32'(($time - t) / 5), 32'(8 * e));
  endtask
  task automatic tog(output int n);
    logic v;
    n = 0;
    repeat (64)
    begin
      @(posedge clk_i);
      v = phase_clk_o;
      @(negedge clk_i);
      if (phase_clk_o !== v)
        n++;
    end
  endtask
  // Phase output against the divided output, delayed by whole oscillator periods
  task automatic ph_rel(input int sh, input logic fl);
    logic [24:0] h;
    int          bad;
    h = 25'h0000000;
    bad = 0;
    repeat (24) @(negedge clk_i);
    for (int i = 0; i < 96; i++)
    begin
      @(negedge clk_i);
      h = {h[23:0], div_clk_o};
      if (i >= 24 && phase_clk_o !== (h[8 * sh] ^ fl))
        bad++;
    end
    chk(32'(bad), 32'h0);
  endtask
  task automatic t_reset;
    rchk(`ROC_OFF_PAUSE, `ROC_RESUME_CODE);
    rchk(`ROC_OFF_DIV, 32'h0000_0AB0);
    rchk(`ROC_OFF_PHASE, 32'h0000_0008);
    rchk(`ROC_OFF_STATUS, 32'h0000_1000);
    rchk(`ROC_OFF_RAWBIT, 32'h0000_0001);
    rchk(`ROC_OFF_COUNT, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_div;
    per(16);
    rchk(`ROC_OFF_STATUS, 32'h8001_1000);
    apb(1'b1, `ROC_OFF_DIV, 32'h0000_0AA3);
    per(3);
    apb(1'b1, `ROC_OFF_DIV, 32'h0000_0BFF);
    rchk(`ROC_OFF_DIV, 32'h0000_0AA0);
    per(32);
  endtask
  task automatic t_bad;
    logic [7:0]  a [6] = '{8'h0C, 8'h0C, 8'h00, 8'h00, 8'h04, 8'h08};
    logic [31:0] d [6] = '{32'h7761_6B65, 32'h0, 32'h00FA_BFA6, 32'h00FA_B123,
                           32'h9696_0000, 32'h1234_0000};
    logic        e [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, a[i], d[i]);
      apb(1'b0, `ROC_OFF_STATUS, 32'h0);
      chk({31'h0, rd[24]}, {31'h0, e[i]});
      apb(1'b1, `ROC_OFF_STATUS, 32'h0);
    end
    // No wake interrupt in this block; the bench resumes by a bus write
    apb(1'b1, `ROC_OFF_PAUSE, `ROC_PAUSE_CODE);
    rchk(`ROC_OFF_PAUSE, `ROC_PAUSE_CODE);
    chk({31'h0, osc_run_o}, 32'h0);
    rchk(`ROC_OFF_STATUS, 32'h0001_1000);
    repeat (8) @(posedge clk_i);
    apb(1'b1, `ROC_OFF_PAUSE, 32'h0000_1234);
    rchk(`ROC_OFF_PAUSE, `ROC_RESUME_CODE);
    chk({31'h0, osc_run_o}, 32'h1);
    rchk(`ROC_OFF_STATUS, 32'h0101_1000);
  endtask
  task automatic t_cnt;
    apb(1'b1, `ROC_OFF_COUNT, 32'h0000_0005);
    repeat (60) @(posedge clk_i);
    rchk(`ROC_OFF_COUNT, 32'h0);
    apb(1'b1, `ROC_OFF_COUNT, 32'h0);
    rchk(`ROC_OFF_COUNT, 32'h0);
    apb(1'b1, `ROC_OFF_COUNT, 32'h0000_00FF);
    repeat (80) @(posedge clk_i);
    apb(1'b0, `ROC_OFF_COUNT, 32'h0);
    chk({31'h0, rd < 32'hFF && rd > 32'hF0}, 32'h1);
  endtask
  task automatic t_phase;
    int n;
    apb(1'b1, `ROC_OFF_DIV, 32'h0000_0AA2);
    apb(1'b1, `ROC_OFF_PHASE, 32'h0000_0AA0);
    repeat (8) @(posedge clk_i);
    tog(n);
    chk(32'(n), 32'h0);
    apb(1'b1, `ROC_OFF_PHASE, 32'h0000_0000);
    tog(n);
    chk({31'h0, n > 0}, 32'h1);
    ph_rel(0, 1'b0);
    apb(1'b1, `ROC_OFF_DIV, 32'h0000_0AA4);
    apb(1'b1, `ROC_OFF_PHASE, 32'h0000_0AAD);
    ph_rel(1, 1'b1);
    // Shift goes to zero before divide by one is chosen
    apb(1'b1, `ROC_OFF_PHASE, 32'h0000_0AAC);
    apb(1'b1, `ROC_OFF_DIV, 32'h0000_0AA1);
    ph_rel(0, 1'b0);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    osc_on <= 1'b1;
    t_div;
    t_bad;
    t_cnt;
    t_phase;
    test_done;
  end
endmodule // ring_osc_control_tail_bench
